/* pmu_ctrl_params.svh */
// Constants of the power-management control and thermal register bank.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PMU_CTRL_PARAMS_SVH
`define PMU_CTRL_PARAMS_SVH

`define PMU_ADDR_ENABLE    8'h08
`define PMU_ADDR_DISCHARGE 8'h09
`define PMU_ADDR_STATUS    8'h0A
`define PMU_ADDR_FLAGS     8'h0B
`define PMU_ADDR_MASK      8'h0C

`define PMU_RST_ENABLE     8'h3F
`define PMU_RST_DISCHARGE  8'h3F
`define PMU_RST_MASK       8'h03

`define PMU_BIT_SLEEP      6
`define PMU_BIT_SELECT_A   7
`define PMU_BIT_KEEP_REGS  7
`define PMU_BIT_SHUTDOWN   1
`define PMU_BIT_WARNING    0
`define PMU_NUM_OUTPUTS    6

`define PMU_OSC_FREQ_KHZ   2000
`define PMU_I2C_ADDR       7'h7C
`define PMU_I2C_BITS       4'h8

`endif

/* pmu_ctrl_pkg.sv */
// Types shared by the register bank and its serial slave.
// Assumes the constants header sits in the same folder.
`include "pmu_ctrl_params.svh"
package pmu_ctrl_pkg;

    typedef enum logic [3:0] {
        PWR_STANDBY  = 4'h1,
        PWR_STARTUP  = 4'h2,
        PWR_IDLE     = 4'h4,
        PWR_SHUTDOWN = 4'h8
    } pmu_pwr_state_t;

    typedef enum logic [6:0] {
        I2C_IDLE = 7'h01,
        I2C_ADDR = 7'h02,
        I2C_REG  = 7'h04,
        I2C_WR   = 7'h08,
        I2C_ACK  = 7'h10,
        I2C_RD   = 7'h20,
        I2C_MACK = 7'h40
    } pmu_i2c_state_t;

endpackage : pmu_ctrl_pkg

/* pmu_i2c_slave.sv */
// Serial two-wire slave giving byte access to the register bank.
// Assumes scl and sda arrive synchronous to mclk and far slower than it.
`timescale 1ns/1ps
`default_nettype none
`include "pmu_ctrl_params.svh"
module pmu_i2c_slave
    import pmu_ctrl_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `PMU_I2C_ADDR
) (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       scl,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic [7:0]      reg_addr,
    output logic            wr_strobe,
    output logic [7:0]      wr_data,
    output logic            rd_strobe,
    input  wire logic [7:0] rd_data
);

    pmu_i2c_state_t state;
    pmu_i2c_state_t after_ack;
    logic [3:0]     bit_cnt;
    logic [7:0]     shift;
    logic           scl_q;
    logic           sda_q;
    logic           scl_rise;
    logic           scl_fall;
    logic           bus_start;
    logic           bus_stop;

    // Open drain: only ever pulls low
    assign sda_out   = 1'h0;
    assign scl_rise  = scl & ~scl_q;
    assign scl_fall  = ~scl & scl_q;
    assign bus_start = scl & scl_q & sda_q & ~sda_in;
    assign bus_stop  = scl & scl_q & ~sda_q & sda_in;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            scl_q <= 1'h1;
            sda_q <= 1'h1;
        end else begin
            scl_q <= scl;
            sda_q <= sda_in;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state     <= I2C_IDLE;
            after_ack <= I2C_IDLE;
            bit_cnt   <= 4'h0;
            shift     <= 8'h00;
            sda_oe    <= 1'h0;
            reg_addr  <= 8'h00;
            wr_strobe <= 1'h0;
            wr_data   <= 8'h00;
            rd_strobe <= 1'h0;
        end else begin
            wr_strobe <= 1'h0;
            rd_strobe <= 1'h0;
            // Auto-increment after each byte moved
            if (wr_strobe || rd_strobe) begin
                reg_addr <= reg_addr + 8'h01;
            end
            if (bus_start) begin
                state   <= I2C_ADDR;
                bit_cnt <= 4'h0;
                sda_oe  <= 1'h0;
            end else if (bus_stop) begin
                state  <= I2C_IDLE;
                sda_oe <= 1'h0;
            end else begin
                case (state)
                    I2C_ADDR, I2C_REG, I2C_WR: begin
                        if (scl_rise && bit_cnt != `PMU_I2C_BITS) begin
                            shift   <= {shift[6:0], sda_in};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == `PMU_I2C_BITS) begin
                            bit_cnt   <= 4'h0;
                            sda_oe    <= 1'h1;
                            state     <= I2C_ACK;
                            after_ack <= I2C_WR;
                            case (state)
                                I2C_ADDR: begin
                                    if (shift[7:1] == DEV_ADDR) begin
                                        after_ack <= shift[0] ? I2C_RD
                                                              : I2C_REG;
                                    end else begin
                                        sda_oe <= 1'h0;
                                        state  <= I2C_IDLE;
                                    end
                                end
                                I2C_REG: begin
                                    reg_addr <= shift;
                                end
                                default: begin
                                    wr_strobe <= 1'h1;
                                    wr_data   <= shift;
                                end
                            endcase
                        end
                    end
                    I2C_ACK: begin
                        if (scl_fall) begin
                            sda_oe <= 1'h0;
                            state  <= after_ack;
                            if (after_ack == I2C_RD) begin
                                shift     <= rd_data;
                                sda_oe    <= ~rd_data[7];
                                bit_cnt   <= 4'h1;
                                rd_strobe <= 1'h1;
                            end
                        end
                    end
                    I2C_RD: begin
                        if (scl_fall) begin
                            if (bit_cnt == `PMU_I2C_BITS) begin
                                sda_oe <= 1'h0;
                                state  <= I2C_MACK;
                            end else begin
                                sda_oe  <= ~shift[6];
                                shift   <= {shift[6:0], 1'h0};
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    I2C_MACK: begin
                        // Master NACK ends the read burst
                        if (scl_rise) begin
                            if (sda_in) begin
                                state <= I2C_IDLE;
                            end else begin
                                state     <= I2C_ACK;
                                after_ack <= I2C_RD;
                            end
                        end
                    end
                    default: begin
                        state <= I2C_IDLE;
                    end
                endcase
            end
        end
    end

endmodule : pmu_i2c_slave
`default_nettype wire

/* pmu_ctrl_regs.sv */
// Control and thermal register bank of the power-management unit, with
// power-state control and the thermal interrupt.
// Assumes temperature comparators, the power-up sequencer and the analog
// regulators sit outside and are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
`include "pmu_ctrl_params.svh"
module pmu_ctrl_regs
    import pmu_ctrl_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `PMU_I2C_ADDR,
    parameter int         NOUT     = `PMU_NUM_OUTPUTS
) (
    input  wire logic            mclk,
    input  wire logic            reset_n,
    input  wire logic            scl,
    input  wire logic            sda_in,
    output logic                 sda_out,
    output logic                 sda_oe,
    input  wire logic            en_pin,
    input  wire logic            voltage_select_pin,
    input  wire logic            pin_low_power_select,
    input  wire logic            pin_voltage_select,
    input  wire logic            sequence_done,
    input  wire logic            temp_over_warning,
    input  wire logic            temp_over_shutdown,
    input  wire logic            temp_below_recovery,
    output logic [NOUT-1:0]      regulator_on,
    output logic [NOUT-1:0]      sequence_include,
    output logic [NOUT-1:0]      discharge_on,
    output logic                 sleep_active,
    output logic                 use_stepdown_code_a,
    output logic                 start_sequence,
    output logic                 emergency_shutdown,
    output logic                 irq_n_out,
    output logic                 irq_n_oe
);

    function automatic logic is_reg(input logic [7:0] addr,
                                    input logic [7:0] offset);
        is_reg = (addr == offset);
    endfunction : is_reg

    logic [7:0]     reg_addr;
    logic           wr_strobe;
    logic [7:0]     wr_data;
    logic           rd_strobe;
    logic [7:0]     rd_data;
    logic [7:0]     output_enable_and_mode;
    logic [7:0]     output_discharge_and_restart;
    logic [7:0]     thermal_interrupt_masks;
    logic [1:0]     thermal_interrupt_flags;
    logic           overheat_warning_status;
    logic           overheat_shutdown_status;
    logic           restart_defaults;
    logic           set_shutdown_flag;
    logic           set_warning_flag;
    logic           clear_flags;
    pmu_pwr_state_t pwr_state;
    pmu_pwr_state_t next_pwr_state;

    pmu_i2c_slave #(
        .DEV_ADDR (DEV_ADDR)
    ) u_slave (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .scl       (scl),
        .sda_in    (sda_in),
        .sda_out   (sda_out),
        .sda_oe    (sda_oe),
        .reg_addr  (reg_addr),
        .wr_strobe (wr_strobe),
        .wr_data   (wr_data),
        .rd_strobe (rd_strobe),
        .rd_data   (rd_data)
    );

    // Power state; overtemperature overrides every other transition
    always_comb begin
        next_pwr_state = pwr_state;
        case (pwr_state)
            PWR_STANDBY: begin
                if (en_pin) begin
                    next_pwr_state = PWR_STARTUP;
                end
            end
            PWR_STARTUP: begin
                if (!en_pin) begin
                    next_pwr_state = PWR_STANDBY;
                end else if (sequence_done) begin
                    next_pwr_state = PWR_IDLE;
                end
            end
            PWR_IDLE: begin
                if (!en_pin) begin
                    next_pwr_state = PWR_STANDBY;
                end
            end
            PWR_SHUTDOWN: begin
                if (temp_below_recovery) begin
                    next_pwr_state = en_pin ? PWR_STARTUP
                                            : PWR_STANDBY;
                end
            end
            default: begin
                next_pwr_state = PWR_STANDBY;
            end
        endcase
        if (temp_over_shutdown) begin
            next_pwr_state = PWR_SHUTDOWN;
        end
    end

    assign restart_defaults = (pwr_state == PWR_SHUTDOWN)
        && (next_pwr_state == PWR_STARTUP)
        && !output_discharge_and_restart[`PMU_BIT_KEEP_REGS];

    // Whole bank runs from the single oscillator clock
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pwr_state <= PWR_STANDBY;
        end else begin
            pwr_state <= next_pwr_state;
        end
    end

    // Writable registers; a restart without keep reloads defaults
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            output_enable_and_mode       <= `PMU_RST_ENABLE;
            output_discharge_and_restart <= `PMU_RST_DISCHARGE;
            thermal_interrupt_masks      <= `PMU_RST_MASK;
        end else if (restart_defaults) begin
            output_enable_and_mode       <= `PMU_RST_ENABLE;
            output_discharge_and_restart <= `PMU_RST_DISCHARGE;
            thermal_interrupt_masks      <= `PMU_RST_MASK;
        end else if (wr_strobe) begin
            if (is_reg(reg_addr, `PMU_ADDR_ENABLE)) begin
                output_enable_and_mode <= wr_data;
            end
            if (is_reg(reg_addr, `PMU_ADDR_DISCHARGE)) begin
                output_discharge_and_restart <= wr_data;
            end
            if (is_reg(reg_addr, `PMU_ADDR_MASK)) begin
                thermal_interrupt_masks <= wr_data;
            end
        end
    end

    // Sticky flags: a set in the clearing read's cycle survives
    assign set_shutdown_flag = (next_pwr_state == PWR_SHUTDOWN)
                               && (pwr_state != PWR_SHUTDOWN);
    assign set_warning_flag  = temp_over_warning && !overheat_warning_status;
    assign clear_flags       = rd_strobe && is_reg(reg_addr, `PMU_ADDR_FLAGS);
    assign overheat_shutdown_status = (pwr_state == PWR_SHUTDOWN);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            overheat_warning_status <= 1'h0;
            thermal_interrupt_flags <= 2'h0;
        end else begin
            overheat_warning_status <= temp_over_warning;
            thermal_interrupt_flags <=
                (thermal_interrupt_flags & ~{2{clear_flags}})
                | {set_shutdown_flag, set_warning_flag};
        end
    end

    always_comb begin
        rd_data = 8'h00;
        case (reg_addr)
            `PMU_ADDR_ENABLE:    rd_data = output_enable_and_mode;
            `PMU_ADDR_DISCHARGE: rd_data = output_discharge_and_restart;
            `PMU_ADDR_STATUS:    rd_data = {6'h00, overheat_shutdown_status,
                                            overheat_warning_status};
            `PMU_ADDR_FLAGS:     rd_data = {6'h00, thermal_interrupt_flags};
            `PMU_ADDR_MASK:      rd_data = thermal_interrupt_masks;
            default:             rd_data = 8'h00;
        endcase
    end

    // Registered controls toward the analog side
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            regulator_on        <= '0;
            sequence_include    <= '0;
            discharge_on        <= '0;
            sleep_active        <= 1'h0;
            use_stepdown_code_a <= 1'h0;
            start_sequence      <= 1'h0;
            emergency_shutdown  <= 1'h0;
        end else begin
            // Sequencer owns the outputs outside idle
            regulator_on <= (pwr_state == PWR_IDLE)
                ? output_enable_and_mode[NOUT-1:0] : '0;
            sequence_include <= output_enable_and_mode[NOUT-1:0];
            discharge_on <= output_discharge_and_restart[NOUT-1:0];
            sleep_active <= pin_low_power_select
                ? !voltage_select_pin
                : output_enable_and_mode[`PMU_BIT_SLEEP];
            use_stepdown_code_a <= pin_voltage_select
                ? voltage_select_pin
                : output_enable_and_mode[`PMU_BIT_SELECT_A];
            start_sequence <= (next_pwr_state == PWR_STARTUP)
                              && (pwr_state != PWR_STARTUP);
            emergency_shutdown <= (next_pwr_state == PWR_SHUTDOWN);
        end
    end

    // Open-drain interrupt, pulls low only
    assign irq_n_out = 1'h0;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_n_oe <= 1'h0;
        end else begin
            irq_n_oe <= |(thermal_interrupt_flags
                          & ~thermal_interrupt_masks[1:0]);
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    a_shutdown_entry: assert property (
        temp_over_shutdown |=> emergency_shutdown && overheat_shutdown_status)
        else $error("overtemperature did not force shutdown");

    a_status_tracks: assert property (
        $rose(emergency_shutdown) |-> overheat_shutdown_status
            && thermal_interrupt_flags[1])
        else $error("shutdown status or flag missing");

    a_warning_sets: assert property (
        $rose(temp_over_warning) |=> thermal_interrupt_flags[0]
            && overheat_warning_status)
        else $error("warning did not set status and flag");

    a_irq_gating: assert property (
        (|(thermal_interrupt_flags & ~thermal_interrupt_masks[1:0]))
            |=> irq_n_oe)
        else $error("unmasked flag did not drive irq");

    a_irq_release: assert property (
        ((thermal_interrupt_flags & ~thermal_interrupt_masks[1:0]) == 2'h0)
            |=> !irq_n_oe)
        else $error("irq driven with no unmasked flag");

    a_flag_read_clear: assert property (
        clear_flags && !set_warning_flag && !set_shutdown_flag
            |=> thermal_interrupt_flags == 2'h0)
        else $error("flag read did not clear flags");

    a_hold_until_cool: assert property (
        pwr_state == PWR_SHUTDOWN && !temp_below_recovery
            |=> pwr_state == PWR_SHUTDOWN)
        else $error("left shutdown before cooling");

    a_restart_defaults: assert property (
        restart_defaults |=> output_enable_and_mode == `PMU_RST_ENABLE
            && thermal_interrupt_masks == `PMU_RST_MASK
            && pwr_state == PWR_STARTUP)
        else $error("restart did not restore defaults");

    a_idle_enable: assert property (
        wr_strobe && is_reg(reg_addr, `PMU_ADDR_ENABLE)
            && pwr_state == PWR_IDLE ##1 pwr_state == PWR_IDLE
            |=> regulator_on == $past(wr_data[NOUT-1:0], 2))
        else $error("idle enable write not applied");

    a_sleep_pin: assert property (
        pin_low_power_select |=> sleep_active == !$past(voltage_select_pin))
        else $error("pin sleep control wrong");

    a_code_soft: assert property (
        !pin_voltage_select |=> use_stepdown_code_a
            == $past(output_enable_and_mode[`PMU_BIT_SELECT_A]))
        else $error("software code select wrong");

    a_standby_off: assert property (
        pwr_state != PWR_IDLE |=> regulator_on == '0)
        else $error("output switched on outside idle");

    a_warning_level: assert property (
        1'b1 |=> overheat_warning_status == $past(temp_over_warning))
        else $error("warning status does not follow temperature");

    a_discharge_write: assert property (
        wr_strobe && is_reg(reg_addr, `PMU_ADDR_DISCHARGE)
            && !restart_defaults
            |=> ##1 discharge_on == $past(wr_data[NOUT-1:0], 2))
        else $error("discharge write not applied");

    a_sleep_soft: assert property (
        !pin_low_power_select |=> sleep_active
            == $past(output_enable_and_mode[`PMU_BIT_SLEEP]))
        else $error("software sleep select wrong");

    a_code_pin: assert property (
        pin_voltage_select |=> use_stepdown_code_a
            == $past(voltage_select_pin))
        else $error("pin code select wrong");

    c_idle_write: cover property (wr_strobe && pwr_state == PWR_IDLE);
    c_shutdown_restart: cover property (
        pwr_state == PWR_SHUTDOWN ##1 pwr_state == PWR_STARTUP);
    c_warning_irq: cover property (set_warning_flag ##1 irq_n_oe);
    c_flag_read: cover property (clear_flags);

endmodule : pmu_ctrl_regs
`default_nettype wire

/* pmu_host_model.sv */
// Behavioural serial host that reads and writes the register bank.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module pmu_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h7C
) (
    input  wire logic mclk,
    input  wire logic sda,
    output var logic  scl,
    output var logic  sda_low
);
    int nack_count = 0;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Five mclk a phase keeps every line change well apart for the slave
    task automatic gap();
        repeat (5) @(negedge mclk);
    endtask : gap
    task automatic bit_io(input logic b, output logic r);
        gap();
        sda_low = !b;
        gap();
        scl = 1'b1;
        gap();
        r = sda;
        scl = 1'b0;
    endtask : bit_io
    // Ninth slot is always released; want says whether a slave ack is due
    task automatic byte_io(input logic [7:0] d, input logic want,
                           output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
        bit_io(1'b1, a);
        if (want && a !== 1'b0) nack_count++;
    endtask : byte_io
    task automatic start();
        if (!scl) begin
            gap();
            sda_low = 1'b0;
            gap();
            scl = 1'b1;
        end
        gap();
        sda_low = 1'b1;
        gap();
        scl = 1'b0;
    endtask : start
    task automatic stop();
        gap();
        sda_low = 1'b1;
        gap();
        scl = 1'b1;
        gap();
        sda_low = 1'b0;
        gap();
    endtask : stop
    // Callers keep enable bits clear for outputs set never to start
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        start();
        byte_io({DEV_ADDR, 1'b0}, 1'b1, r);
        byte_io(a, 1'b1, r);
        byte_io(d, 1'b1, r);
        stop();
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] r;
        start();
        byte_io({DEV_ADDR, 1'b0}, 1'b1, r);
        byte_io(a, 1'b1, r);
        start();
        byte_io({DEV_ADDR, 1'b1}, 1'b1, r);
        byte_io(8'hFF, 1'b0, d);
        stop();
    endtask : read_reg
endmodule : pmu_host_model
`default_nettype wire

/* pmu_ctrl_regs_tb.sv */
// Self-checking bench for the control and thermal register bank.
// Assumes the serial host model drives the bus; bench drives pins.
`timescale 1ns/1ps
`default_nettype none
module pmu_ctrl_regs_tb;
    logic mclk = 1'b0, reset_n = 1'b0, en = 1'b0, vpin = 1'b0;
    logic lp = 1'b0, pv = 1'b0, done = 1'b0, tw = 1'b0, ts = 1'b0;
    logic tr = 1'b0, scl, sda_low, sda_oe, irq_oe, sleep, code_a;
    logic start_seq, emerg, sda_val, irq_val;
    logic [5:0] reg_on, seq_inc, dis_on;
    int errors = 0, num_checks = 0, cycles = 0, n_start = 0;
    wire sda = !(sda_low || sda_oe);
    always #5 mclk = ~mclk;
    pmu_host_model host (.mclk(mclk), .sda(sda), .scl(scl),
                         .sda_low(sda_low));
    pmu_ctrl_regs uut (.mclk(mclk), .reset_n(reset_n), .scl(scl),
        .sda_in(sda), .sda_out(sda_val), .sda_oe(sda_oe), .en_pin(en),
        .voltage_select_pin(vpin), .pin_low_power_select(lp),
        .pin_voltage_select(pv), .sequence_done(done),
        .temp_over_warning(tw), .temp_over_shutdown(ts),
        .temp_below_recovery(tr), .regulator_on(reg_on),
        .sequence_include(seq_inc), .discharge_on(dis_on),
        .sleep_active(sleep), .use_stepdown_code_a(code_a),
        .start_sequence(start_seq), .emergency_shutdown(emerg),
        .irq_n_out(irq_val), .irq_n_oe(irq_oe));
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host.read_reg(a, v);
        chk(v, exp);
    endtask : rd
    // Level inputs settle through two register stages
    task automatic settle();
        repeat (3) @(negedge mclk);
    endtask : settle
    always @(posedge mclk) begin
        cycles++;
        if (start_seq === 1'b1) n_start++;
        if (cycles == 60000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (10) @(negedge mclk);
        reset_n = 1'b1;
        rd(8'h08, 8'h3F);
        rd(8'h09, 8'h3F);
        rd(8'h0B, 8'h00);
        rd(8'h0C, 8'h03);
        rd(8'h0D, 8'h00);
        host.write_reg(8'h0A, 8'hFF);
        rd(8'h0A, 8'h00);
        chk(8'(seq_inc), 8'h3F);
        chk(8'(reg_on), 8'h00);
        chk(8'({irq_val, sda_val}), 8'h00);
        en = 1'b1;
        done = 1'b1;
        settle();
        host.write_reg(8'h08, 8'h05);
        chk(8'(reg_on), 8'h05);
        chk(8'(seq_inc), 8'h05);
        host.write_reg(8'h08, 8'hC5);
        for (int i = 0; i < 8; i++) begin
            lp = i[0];
            pv = i[1];
            vpin = i[2];
            settle();
            chk(8'(sleep), 8'(lp ? !vpin : 1'b1));
            chk(8'(code_a), 8'(pv ? vpin : 1'b1));
        end
        lp = 1'b0;
        pv = 1'b0;
        host.write_reg(8'h08, 8'h05);
        chk(8'({sleep, code_a}), 8'h00);
        host.write_reg(8'h09, 8'h2A);
        chk(8'(dis_on), 8'h2A);
        tw = 1'b1;
        settle();
        chk(8'(irq_oe), 8'h00);
        rd(8'h0A, 8'h01);
        host.write_reg(8'h0C, 8'h00);
        chk(8'(irq_oe), 8'h01);
        rd(8'h0B, 8'h01);
        chk(8'(irq_oe), 8'h00);
        tw = 1'b0;
        rd(8'h0A, 8'h00);
        for (int k = 0; k < 2; k++) begin
            host.write_reg(8'h09, k ? 8'h95 : 8'h15);
            host.write_reg(8'h0C, 8'h00);
            ts = 1'b1;
            settle();
            chk(8'({emerg, irq_oe}), 8'h03);
            rd(8'h0A, 8'h02);
            ts = 1'b0;
            settle();
            chk(8'(emerg), 8'h01);
            tr = 1'b1;
            settle();
            chk(8'(emerg), 8'h00);
            chk(8'(dis_on), k ? 8'h15 : 8'h3F);
            tr = 1'b0;
            rd(8'h09, k ? 8'h95 : 8'h3F);
            rd(8'h0B, 8'h02);
        end
        chk(8'(n_start), 8'h03);
        chk(8'(host.nack_count), 8'h00);
        tally_and_finish();
    end
endmodule : pmu_ctrl_regs_tb
`default_nettype wire
